// ### pcp_pkg.sv
// Package of constants and types shared by both ends of the loop control port
package pcp_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_SETTINGS = 32;
	// Setting map chosen for this shell
	localparam logic [4:0] ADDR_PREDIV = 5'h00;
	localparam logic [4:0] ADDR_FBDIV = 5'h01;
	localparam logic [4:0] ADDR_DIV_P = 5'h02;
	localparam logic [4:0] ADDR_DIV_A = 5'h03;
	localparam logic [4:0] ADDR_DIV_B = 5'h04;
	localparam logic [4:0] ADDR_DIV_C = 5'h05;
	localparam logic [4:0] ADDR_PHASE_P = 5'h06;
	localparam logic [4:0] ADDR_PHASE_A = 5'h07;
	localparam logic [4:0] ADDR_PHASE_B = 5'h08;
	localparam logic [4:0] ADDR_PHASE_C = 5'h09;
	localparam logic [4:0] ADDR_PHASE_SRC = 5'h0a;
	localparam logic [7:0] RST_DIV = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] LOCK_CYCLES = 8'h10;
	typedef enum logic [1:0] {PCP_IDLE, PCP_ACK, PCP_WAIT} pcp_bus_state_t;
endpackage

// ### pcp_bus_if.sv
// Interface joining the settings-bus master and the loop control device
`timescale 1ns/1ps
interface pcp_bus_if;
	logic settings_bus_clock;
	logic settings_bus_reset;
	logic settings_bus_strobe;
	logic settings_bus_write_enable;
	logic [4:0] settings_bus_address;
	logic [7:0] settings_bus_write_data;
	logic [7:0] settings_bus_read_data;
	logic settings_bus_acknowledge;
	modport device (
		input settings_bus_clock, settings_bus_reset, settings_bus_strobe, settings_bus_write_enable,
		input settings_bus_address, settings_bus_write_data,
		output settings_bus_read_data, settings_bus_acknowledge
	);
	modport master (
		output settings_bus_clock, settings_bus_reset, settings_bus_strobe, settings_bus_write_enable,
		output settings_bus_address, settings_bus_write_data,
		input settings_bus_read_data, settings_bus_acknowledge
	);
endinterface // pcp_bus_if

// ### pcp_device.sv
// Digital shell of the loop: output dividers, gating, lock, and settings bus slave
`timescale 1ns/1ps
module pcp_device (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic full_loop_reset_in,
	input wire logic divider_b_reset_in,
	input wire logic divider_c_reset_in,
	input wire logic loop_powerdown_in,
	input wire logic primary_out_gate_in,
	input wire logic secondary_a_gate_in,
	input wire logic secondary_b_gate_in,
	input wire logic secondary_c_gate_in,
	input wire logic [7:0] port_phase_in,
	pcp_bus_if.device bus,
	output logic primary_out_clock_out,
	output logic secondary_out_clock_a_out,
	output logic secondary_out_clock_b_out,
	output logic secondary_out_clock_c_out,
	output logic lock_out,
	output logic phase_source_indicator_out
);
	import pcp_pkg::*;
	logic [7:0] set_q [NUM_SETTINGS];
	logic [7:0] set_d [NUM_SETTINGS];
	pcp_bus_state_t st_q, st_d;
	logic ack_q, ack_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] prediv_cnt_q, prediv_cnt_d;
	logic ref_tick;
	logic [7:0] lock_cnt_q, lock_cnt_d;
	logic lock_q, lock_d;
	logic [7:0] div_cnt_q [4];
	logic [7:0] div_cnt_d [4];
	logic [3:0] div_clk_q, div_clk_d;
	logic [3:0] gate;
	logic [3:0] div_rst;
	logic [3:0] phase_cfg;
	logic loop_rst;
	logic [7:0] cfg_q [NUM_SETTINGS];
	logic [7:0] cfg_d [NUM_SETTINGS];
	logic wr_tog_q, wr_tog_d;
	logic [2:0] tog_sync_q, tog_sync_d;
	logic cfg_load;

	function automatic logic [7:0] div_limit(input logic [7:0] v);
		div_limit = (v == 8'h00) ? 8'h00 : v - 8'h01;
	endfunction

	function automatic logic [7:0] reset_value(input int idx);
		reset_value = (idx >= int'(ADDR_DIV_P) && idx <= int'(ADDR_DIV_C)) ? RST_DIV : RST_ZERO;
	endfunction

	// Settings bus, clocked only by the master's bus clock; bus reset leaves settings alone
	always_comb begin
		st_d = st_q;
		ack_d = 1'b0;
		rdata_d = rdata_q;
		wr_tog_d = wr_tog_q;
		for (int i = 0; i < NUM_SETTINGS; i++) begin
			set_d[i] = set_q[i];
		end
		unique case (st_q)
			PCP_IDLE: begin
				if (bus.settings_bus_strobe) begin
					ack_d = 1'b1;
					st_d = PCP_ACK;
					if (bus.settings_bus_write_enable) begin
						set_d[bus.settings_bus_address] = bus.settings_bus_write_data;
						wr_tog_d = ~wr_tog_q;
					end else begin
						rdata_d = set_q[bus.settings_bus_address];
					end
				end
			end
			PCP_ACK: begin
				st_d = bus.settings_bus_strobe ? PCP_WAIT : PCP_IDLE;
			end
			PCP_WAIT: begin
				if (!bus.settings_bus_strobe) begin
					st_d = PCP_IDLE;
				end
			end
			default: st_d = PCP_IDLE;
		endcase
	end

	always_ff @(posedge bus.settings_bus_clock or posedge bus.settings_bus_reset) begin
		if (bus.settings_bus_reset) begin
			st_q <= PCP_IDLE;
			ack_q <= 1'b0;
			rdata_q <= RST_ZERO;
		end else begin
			st_q <= st_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// Settings reset only by the system reset, never by the bus reset
	always_ff @(posedge bus.settings_bus_clock or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_tog_q <= 1'b0;
			for (int i = 0; i < NUM_SETTINGS; i++) begin
				set_q[i] <= reset_value(i);
			end
		end else begin
			wr_tog_q <= wr_tog_d;
			for (int i = 0; i < NUM_SETTINGS; i++) begin
				set_q[i] <= set_d[i];
			end
		end
	end

	assign bus.settings_bus_acknowledge = ack_q;
	assign bus.settings_bus_read_data = rdata_q;

	// Settings reach the reference domain as a whole copy once a synchronised write toggle flips
	// Limitation: a write landing during the copy may tear a word, so leave a few cycles between writes
	assign cfg_load = tog_sync_q[1] ^ tog_sync_q[2];

	always_comb begin
		tog_sync_d = {tog_sync_q[1:0], wr_tog_q};
		for (int i = 0; i < NUM_SETTINGS; i++) begin
			cfg_d[i] = cfg_load ? set_q[i] : cfg_q[i];
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tog_sync_q <= 3'h0;
			for (int i = 0; i < NUM_SETTINGS; i++) begin
				cfg_q[i] <= reset_value(i);
			end
		end else begin
			tog_sync_q <= tog_sync_d;
			for (int i = 0; i < NUM_SETTINGS; i++) begin
				cfg_q[i] <= cfg_d[i];
			end
		end
	end

	// Loop model on the reference clock; power-down spares the pre-divider, while full loop reset and system reset clear it
	assign loop_rst = sys_rst_in | full_loop_reset_in | loop_powerdown_in;
	assign gate = {secondary_c_gate_in, secondary_b_gate_in, secondary_a_gate_in, primary_out_gate_in};
	assign div_rst = {divider_c_reset_in, divider_b_reset_in, 2'b00};
	assign ref_tick = (prediv_cnt_q >= div_limit(cfg_q[ADDR_PREDIV]));
	assign phase_cfg = {cfg_q[ADDR_PHASE_C][0], cfg_q[ADDR_PHASE_B][0], cfg_q[ADDR_PHASE_A][0], cfg_q[ADDR_PHASE_P][0]};

	always_comb begin
		prediv_cnt_d = ref_tick ? 8'h00 : prediv_cnt_q + 8'h01;
		if (full_loop_reset_in) begin
			prediv_cnt_d = 8'h00;
		end
		lock_cnt_d = lock_cnt_q;
		lock_d = lock_q;
		if (loop_rst) begin
			lock_cnt_d = 8'h00;
			lock_d = 1'b0;
		end else if (lock_cnt_q == LOCK_CYCLES) begin
			lock_d = 1'b1;
		end else if (ref_tick) begin
			lock_cnt_d = lock_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prediv_cnt_q <= 8'h00;
			lock_cnt_q <= 8'h00;
			lock_q <= 1'b0;
		end else begin
			prediv_cnt_q <= prediv_cnt_d;
			lock_cnt_q <= lock_cnt_d;
			lock_q <= lock_d;
		end
	end

	// Output dividers; each has its own gate, but only dividers B and C have their own reset
	generate
		for (genvar k = 0; k < 4; k++) begin : g_div
			logic [7:0] lim;
			assign lim = div_limit(cfg_q[int'(ADDR_DIV_P) + k]);
			always_comb begin
				div_cnt_d[k] = div_cnt_q[k];
				div_clk_d[k] = div_clk_q[k];
				if (!lock_q || div_rst[k]) begin
					div_cnt_d[k] = 8'h00;
					div_clk_d[k] = phase_cfg[k] ^ port_phase_in[k];
				end else if (div_cnt_q[k] >= lim) begin
					div_cnt_d[k] = 8'h00;
					div_clk_d[k] = ~div_clk_q[k];
				end else begin
					div_cnt_d[k] = div_cnt_q[k] + 8'h01;
				end
			end
			always_ff @(posedge mclk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					div_cnt_q[k] <= 8'h00;
					div_clk_q[k] <= 1'b0;
				end else begin
					div_cnt_q[k] <= div_cnt_d[k];
					div_clk_q[k] <= div_clk_d[k];
				end
			end
		end
	endgenerate

	// Gating after the divider flop keeps the gate glitch-free only if gates are synchronous
	assign primary_out_clock_out = div_clk_q[0] & gate[0];
	assign secondary_out_clock_a_out = div_clk_q[1] & gate[1];
	assign secondary_out_clock_b_out = div_clk_q[2] & gate[2];
	assign secondary_out_clock_c_out = div_clk_q[3] & gate[3];
	assign lock_out = lock_q;
	assign phase_source_indicator_out = cfg_q[ADDR_PHASE_SRC][0];
endmodule // pcp_device

// ### pcp_master.sv
// User-side master that runs single transfers on the settings bus
`timescale 1ns/1ps
module pcp_master (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic bus_reset_req_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [4:0] req_address_in,
	input wire logic [7:0] req_write_data_in,
	pcp_bus_if.master bus,
	output logic req_ready_out,
	output logic done_out,
	output logic [7:0] done_read_data_out
);
	import pcp_pkg::*;
	pcp_bus_state_t st_q, st_d;
	logic stb_q, stb_d;
	logic we_q, we_d;
	logic [4:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic done_q, done_d;
	logic [7:0] rd_q, rd_d;

	// The master supplies the bus clock from its own clock
	assign bus.settings_bus_clock = mclk_in;
	assign bus.settings_bus_reset = bus_reset_req_in;
	assign bus.settings_bus_strobe = stb_q;
	assign bus.settings_bus_write_enable = we_q;
	assign bus.settings_bus_address = addr_q;
	assign bus.settings_bus_write_data = wdata_q;
	assign req_ready_out = (st_q == PCP_IDLE);
	assign done_out = done_q;
	assign done_read_data_out = rd_q;

	always_comb begin
		st_d = st_q;
		stb_d = stb_q;
		we_d = we_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		done_d = 1'b0;
		rd_d = rd_q;
		unique case (st_q)
			PCP_IDLE: begin
				if (req_valid_in) begin
					stb_d = 1'b1;
					we_d = req_write_in;
					addr_d = req_address_in;
					wdata_d = req_write_data_in;
					st_d = PCP_ACK;
				end
			end
			PCP_ACK: begin
				if (bus.settings_bus_acknowledge) begin
					stb_d = 1'b0;
					done_d = 1'b1;
					if (!we_q) begin
						rd_d = bus.settings_bus_read_data;
					end
					st_d = PCP_WAIT;
				end
			end
			PCP_WAIT: begin
				st_d = PCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= PCP_IDLE;
			stb_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 5'h00;
			wdata_q <= 8'h00;
			done_q <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			st_q <= st_d;
			stb_q <= stb_d;
			we_q <= we_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			done_q <= done_d;
			rd_q <= rd_d;
		end
	end
endmodule // pcp_master

// ### pcp_chk.sv
// Handshake checker for the settings bus
`timescale 1ns/1ps
module pcp_chk (
	input wire logic settings_bus_clock,
	input wire logic settings_bus_reset,
	input wire logic settings_bus_strobe,
	input wire logic settings_bus_write_enable,
	input wire logic [4:0] settings_bus_address,
	input wire logic [7:0] settings_bus_write_data,
	input wire logic [7:0] settings_bus_read_data,
	input wire logic settings_bus_acknowledge
);
	wire stb = settings_bus_strobe;
	wire ack = settings_bus_acknowledge;
	wire we = settings_bus_write_enable;
	default clocking cb @(posedge settings_bus_clock); endclocking
	default disable iff (settings_bus_reset);
	property p_ack_late; $rose(stb) |=> ack; endproperty
	a_ack_late: assert property (p_ack_late) else $error("no ack after strobe");
	property p_fresh; $rose(stb) |-> !ack; endproperty
	a_fresh: assert property (p_fresh) else $error("stale ack");
	property p_one; ack |=> !ack; endproperty
	a_one: assert property (p_one) else $error("ack too long");
	property p_ack_stb; ack |-> stb; endproperty
	a_ack_stb: assert property (p_ack_stb) else $error("ack without strobe");
	property p_hold;
		stb && !ack |=> stb && $stable({we, settings_bus_address, settings_bus_write_data});
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_drop; ack |=> !stb; endproperty
	a_drop: assert property (p_drop) else $error("strobe kept");
	property p_fell; $fell(stb) |-> $past(ack); endproperty
	a_fell: assert property (p_fell) else $error("early strobe drop");
	property p_rdata; $changed(settings_bus_read_data) |-> ack && !we; endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	// Main traffic and a bus reset release seen at least once
	c_wr: cover property (ack && we);
	c_rd: cover property (ack && !we);
	c_brst: cover property ($fell(settings_bus_reset));
endmodule // pcp_chk

// ### tb.sv
// Self-checking bench for device and master
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst = 1, flr = 0, rb = 0, rc = 0, pd = 0, brr = 1;
	logic rv = 0, rw = 0, ready, done, lock, psrc;
	logic [3:0] gate = 0;
	wire [3:0] outs;
	logic [4:0] ra = 0;
	logic [7:0] rd = 0, drd, rdat;
	int errors = 0, comparisons = 0;
	pcp_bus_if bus_if ();
	pcp_device i_pcp_device (.mclk_in(clk), .sys_rst_in(rst), .full_loop_reset_in(flr),
		.divider_b_reset_in(rb), .divider_c_reset_in(rc), .loop_powerdown_in(pd),
		.primary_out_gate_in(gate[0]), .secondary_a_gate_in(gate[1]), .secondary_b_gate_in(gate[2]),
		.secondary_c_gate_in(gate[3]), .port_phase_in(8'h05), .bus(bus_if.device),
		.primary_out_clock_out(outs[0]), .secondary_out_clock_a_out(outs[1]),
		.secondary_out_clock_b_out(outs[2]), .secondary_out_clock_c_out(outs[3]),
		.lock_out(lock), .phase_source_indicator_out(psrc));
	pcp_master i_pcp_master (.mclk_in(clk), .sys_rst_in(rst), .bus_reset_req_in(brr),
		.req_valid_in(rv), .req_write_in(rw), .req_address_in(ra), .req_write_data_in(rd),
		.bus(bus_if.master), .req_ready_out(ready), .done_out(done), .done_read_data_out(drd));
	pcp_chk i_pcp_chk (.settings_bus_clock(bus_if.settings_bus_clock),
		.settings_bus_reset(bus_if.settings_bus_reset), .settings_bus_strobe(bus_if.settings_bus_strobe),
		.settings_bus_write_enable(bus_if.settings_bus_write_enable),
		.settings_bus_address(bus_if.settings_bus_address),
		.settings_bus_write_data(bus_if.settings_bus_write_data),
		.settings_bus_read_data(bus_if.settings_bus_read_data),
		.settings_bus_acknowledge(bus_if.settings_bus_acknowledge));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One transfer; an extra edge lets the master return to idle
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		chk({7'h0, ready}, 8'h01);
		rv = 1;
		rw = w;
		ra = a;
		rd = d;
		@(posedge clk);
		#1 rv = 0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		rdat = drd;
		chk({7'h0, n == 20}, 8'h00);
		@(posedge clk);
		#1;
	endtask
	task automatic tog(input logic [3:0] exp);
		logic [3:0] p, m;
		m = 4'h0;
		// Let gate, divider reset and lock changes settle before watching for edges
		repeat (2) @(posedge clk);
		#1 p = outs;
		repeat (8) begin
			@(posedge clk);
			#1 m = m | (outs ^ p);
			p = outs;
		end
		chk({4'h0, m}, {4'h0, exp});
	endtask
	// Lock is a slow level, so wait on it with a bound
	task automatic wlock(input logic e);
		int n;
		n = 0;
		while (lock !== e && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		chk({7'h0, lock}, {7'h0, e});
	endtask
	task automatic t_lock;
		wlock(1);
		flr = 1;
		wlock(0);
		flr = 0;
		wlock(1);
		pd = 1;
		wlock(0);
		pd = 0;
		wlock(1);
		rst = 1;
		@(posedge clk);
		#1 chk({7'h0, lock}, 8'h00);
		rst = 0;
		wlock(1);
	endtask
	task automatic t_rw;
		for (int a = 0; a < 11; a++) begin
			xfer(1, 5'(a), 8'(a + 1));
			xfer(0, 5'(a), 8'h00);
			chk(rdat, 8'(a + 1));
		end
		chk({7'h0, psrc}, 8'h01);
		xfer(1, 5'h0a, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		chk({7'h0, psrc}, 8'h00);
		xfer(1, 5'h1f, 8'hc3);
		xfer(0, 5'h1f, 8'h00);
		chk(rdat, 8'hc3);
	endtask
	task automatic t_bus_reset;
		xfer(1, 5'h08, 8'h3c);
		brr = 1;
		repeat (2) @(posedge clk);
		#1 brr = 0;
		xfer(0, 5'h08, 8'h00);
		chk(rdat, 8'h3c);
	endtask
	task automatic t_gate;
		tog(4'h0);
		for (int i = 0; i < 4; i++) begin
			gate = 4'(1 << i);
			tog(4'(1 << i));
		end
		gate = 4'hf;
		rb = 1;
		tog(4'hb);
		rb = 0;
		rc = 1;
		tog(4'h7);
		rc = 0;
		pd = 1;
		tog(4'h0);
		pd = 0;
	endtask
	task give_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 0;
		brr = 0;
		t_lock();
		t_rw();
		t_bus_reset();
		t_gate();
		give_verdict();
	end
	// Whole run needs a few hundred cycles
	initial begin
		#100000 errors++;
		give_verdict();
	end
endmodule // tb
